// *** verilog/nvm_access_defines.vh ***
// Offsets, field positions, reset values and sizes for the memory access block
`ifndef NVM_ACCESS_DEFINES_VH
`define NVM_ACCESS_DEFINES_VH
// Configuration latch byte offsets
`define CFG_PORT_DRIVE_LOW 2'h0
`define CFG_PORT_DRIVE_HIGH 2'h1
`define CFG_RESET_DEBUG 2'h2
`define CFG_CLOCK_ECC_DEBUG 2'h3
// Register port addresses: the latch bytes, then the control and status registers
`define REG_ADDR_W 4
`define REG_LATCH0 4'h0
`define REG_LATCH1 4'h1
`define REG_LATCH2 4'h2
`define REG_LATCH3 4'h3
`define REG_STATUS 4'h4
`define REG_ERR_CLEAR 4'h5
`define REG_PROTECT_ERASE 4'h6
// Factory defaults of the latch bytes
`define CFG0_RESET 8'h00
`define CFG1_RESET 8'h00
`define CFG2_RESET 8'h40
`define CFG3_RESET 8'h02
// Field positions in byte 2 and byte 3
`define F_RESET_PIN 7
`define F_DEBUG_EN 6
`define F_PHASE_HI 7
`define F_PHASE_LO 4
`define F_CHECK_EN 3
`define F_DPS_HI 2
`define F_DPS_LO 1
`define F_BOOT_SPEED 0
// Protection levels
`define PROT_NONE 2'h0
`define PROT_FACTORY 2'h1
`define PROT_FIELD 2'h2
`define PROT_FULL 2'h3
// Memory geometry
`define SRAM_BLOCK_BIT 15
`define FLASH_BLOCK_DATA 256
`define FLASH_BLOCK_CHECK 32
`define EE_ROWS 128
`define EE_ROW_BYTES 16
`endif

// *** verilog/nvm_access.v ***
// Memory access logic: SRAM arbitration, flash check and correction, protection, EEPROM, config latches
// Summary of operation
// RULE1 - CPU and DMA share SRAM concurrently only in different 32 KB blocks.
// RULE2 - Each 8 data bytes: correct single-bit, detect double-bit error, flag it.
// RULE3 - Flash word is 9 bytes: 8 data plus 1 check byte.
// RULE4 - All flash reads go through cache path; corrected when checking enabled.
// RULE5 - No instruction fetch from the check-byte flash region.
// RULE6 - Flash programming stalls flash fetches; SRAM execution continues.
// RULE7 - Flash block holds 256 data bytes plus 32 check bytes.
// RULE8 - Each row has one of four levels, changed only by full erase.
// RULE9 - None all; factory no external read; field no external; full internal read.
// RULE10 - EEPROM reads direct by byte; writes only via programming commands.
// RULE11 - EEPROM written and erased by whole 16-byte rows, 128 rows.
// RULE12 - No fetch from EEPROM, and no correction on EEPROM data.
// RULE13 - Controller should avoid reset during up to 20 ms writes.
// RULE14 - Four configuration latch bytes configure the device at reset.
// RULE15 - Port drive field: analog, digital, pull-up, pull-down for all pins.
// RULE16 - Reset-pin select: 0 general I/O, 1 external reset input.
// RULE17 - Debug access: 0 blocked, 1 granted.
// RULE18 - Boot clock select: 0 12 MHz, 1 48 MHz.
// RULE19 - Debug port select: 5-wire, 4-wire, serial wire, disabled.
// RULE20 - Check region enable: 0 correction off, 1 region holds check codes.
// RULE21 - Four-bit field selects digital clock phase delay.
// RULE22 - Latch configuration into controls before internal reset releases.
`timescale 1ns/1ps
`include "nvm_access_defines.vh"
module nvm_access #(
    parameter PROT_ROWS = 16,
    parameter ROW_W = 4
) (
    input wire clock,
    input wire rstn,
    // Register port
    input wire [3:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_write,
    input wire reg_read,
    output reg [7:0] reg_rdata,
    // SRAM requests
    input wire cpu_sram_req,
    input wire [15:0] cpu_sram_addr,
    input wire dma_sram_req,
    input wire [15:0] dma_sram_addr,
    output reg cpu_sram_grant,
    output reg dma_sram_grant,
    // Flash read through cache path
    input wire flash_req,
    input wire flash_fetch,
    input wire flash_check_area,
    input wire flash_external,
    input wire [ROW_W-1:0] flash_row,
    input wire [71:0] flash_word,
    input wire flash_program_busy,
    output reg [63:0] flash_rdata,
    output reg flash_rvalid,
    output reg flash_denied,
    output reg flash_stall,
    output reg ecc_error_event,
    // Protection writes
    input wire prot_write,
    input wire prot_external,
    input wire [ROW_W-1:0] prot_row,
    output reg prot_write_ok,
    // EEPROM
    input wire ee_read,
    input wire ee_fetch,
    input wire [10:0] ee_addr,
    output reg [7:0] ee_rdata,
    output reg ee_rvalid,
    output reg ee_fault,
    input wire ee_row_write,
    input wire [6:0] ee_row,
    input wire [127:0] ee_row_data,
    // Configuration latch load
    input wire cfg_load,
    input wire [31:0] cfg_bytes,
    output reg cfg_internal_resetn,
    output reg [15:0] port_reset_drive_mode,
    output reg reset_pin_function_select,
    output reg debug_access_enable,
    output reg boot_clock_speed_select,
    output reg [1:0] debug_port_select,
    output reg check_region_enable,
    output reg [3:0] digital_clock_phase_delay
);

    reg [7:0] cfg [0:3];
    reg [1:0] prot_level [0:PROT_ROWS-1];
    reg [7:0] ee_mem [0:`EE_ROWS*`EE_ROW_BYTES-1];

    reg err_single;
    reg err_double;
    reg cfg_loaded;
    reg prot_erase_req;

    reg [63:0] corrected;
    reg [7:0] syndrome;
    reg [6:0] hsyn;
    reg parity_bad;
    reg single_err;
    reg double_err;
    reg [63:0] fix_mask;
    reg [7:0] check_calc;
    reg ecc_armed;
    // Error kind travels with its event; the word on the lines has moved on by then
    reg ecc_hit_single;
    reg ecc_hit_double;
    wire [15:0] drive_fields;

    integer i;
    integer k;
    integer e;

    // One check byte guards as many data bytes as a block holds per check byte
    localparam CHECK_SPAN = `FLASH_BLOCK_DATA / `FLASH_BLOCK_CHECK; // RULE7

    // Hamming check of one 64-bit group plus overall parity
    // Data bits fill the positions that are not powers of two; check[7] evens the whole word
    function [7:0] hamming_check;
        input [63:0] d;
        integer b;
        integer p;
        integer pos;
        reg [7:0] c;
        begin
            c = 8'h00;
            pos = 3;
            for (b = 0; b < 64; b = b + 1) begin
                while ((pos & (pos - 1)) == 0)
                    pos = pos + 1;
                for (p = 0; p < 7; p = p + 1)
                    if (pos[p])
                        c[p] = c[p] ^ d[b];
                pos = pos + 1;
            end
            c[7] = ^d ^ ^c[6:0];
            hamming_check = c;
        end
    endfunction

    // Bit position of each data bit in the Hamming word
    function [6:0] data_pos;
        input integer idx;
        integer b;
        integer pos;
        begin
            pos = 3;
            for (b = 0; b <= idx; b = b + 1) begin
                while ((pos & (pos - 1)) == 0)
                    pos = pos + 1;
                if (b < idx)
                    pos = pos + 1;
            end
            data_pos = pos[6:0];
        end
    endfunction

    always @* begin
        check_calc = hamming_check(flash_word[8*CHECK_SPAN-1:0]); // RULE3
        syndrome = check_calc ^ flash_word[8*CHECK_SPAN +: 8];
        hsyn = syndrome[6:0];
        // A clean word has even parity over all 72 lines, so one flipped line shows here
        parity_bad = ^flash_word;
        ecc_armed = check_region_enable && !flash_check_area;
        single_err = parity_bad; // RULE2
        double_err = !parity_bad && (hsyn != 7'h00); // RULE2
        fix_mask = 64'h0000_0000_0000_0000;
        for (k = 0; k < 64; k = k + 1)
            if (parity_bad && hsyn == data_pos(k))
                fix_mask[k] = 1'b1;
        corrected = check_region_enable ? (flash_word[63:0] ^ fix_mask) : flash_word[63:0]; // RULE4
    end

    // One drive field per port, ports 0-3 in byte 0 and 4-7 in byte 1
    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : g_port_drive
            assign drive_fields[2*g +: 2] = cfg[g / 4][2*(g % 4) +: 2]; // RULE15
        end
    endgenerate

    // Access decision from the row protection level
    // The full level refuses writes even from inside
    function allow_access;
        input [1:0] level;
        input ext;
        input wr;
        begin
            case (level)
                `PROT_NONE: allow_access = 1'b1;
                `PROT_FACTORY: allow_access = !(ext && !wr);
                `PROT_FIELD: allow_access = !ext;
                default: allow_access = !ext && !wr;
            endcase
        end
    endfunction

    // Configuration latches and decoded controls
    always @(posedge clock) begin
        if (!rstn) begin
            cfg[0] <= `CFG0_RESET;
            cfg[1] <= `CFG1_RESET;
            cfg[2] <= `CFG2_RESET;
            cfg[3] <= `CFG3_RESET;
            cfg_loaded <= 1'b0;
            cfg_internal_resetn <= 1'b0;
        end else begin
            // Loaded once per reset; later load pulses are ignored
            if (cfg_load && !cfg_loaded) begin
                cfg[0] <= cfg_bytes[7:0]; // RULE14
                cfg[1] <= cfg_bytes[15:8];
                cfg[2] <= cfg_bytes[23:16];
                cfg[3] <= cfg_bytes[31:24];
                cfg_loaded <= 1'b1;
            end else if (reg_write && reg_addr <= `REG_LATCH3) begin
                // Rewrites after release never reach the controls; the next reset reloads the defaults
                cfg[reg_addr[1:0]] <= reg_wdata;
            end
            cfg_internal_resetn <= cfg_loaded; // RULE22
        end
    end

    // Controls follow the latches while the internal reset is held, then freeze
    always @(posedge clock) begin
        if (!rstn) begin
            port_reset_drive_mode <= {`CFG1_RESET, `CFG0_RESET};
            reset_pin_function_select <= 1'b0;
            debug_access_enable <= 1'b1;
            boot_clock_speed_select <= 1'b0;
            debug_port_select <= 2'h1;
            check_region_enable <= 1'b0;
            digital_clock_phase_delay <= 4'h0;
        end else if (!cfg_internal_resetn) begin
            port_reset_drive_mode <= drive_fields; // RULE15
            reset_pin_function_select <= cfg[2][`F_RESET_PIN]; // RULE16
            debug_access_enable <= cfg[2][`F_DEBUG_EN]; // RULE17
            boot_clock_speed_select <= cfg[3][`F_BOOT_SPEED]; // RULE18
            debug_port_select <= cfg[3][`F_DPS_HI:`F_DPS_LO]; // RULE19
            check_region_enable <= cfg[3][`F_CHECK_EN]; // RULE20
            digital_clock_phase_delay <= cfg[3][`F_PHASE_HI:`F_PHASE_LO]; // RULE21
        end
    end

    // SRAM arbitration, CPU wins a same-block clash
    // A refused DMA request simply holds until the blocks differ or the CPU lets go
    always @(posedge clock) begin
        if (!rstn) begin
            cpu_sram_grant <= 1'b0;
            dma_sram_grant <= 1'b0;
        end else begin
            cpu_sram_grant <= cpu_sram_req;
            dma_sram_grant <= dma_sram_req && !(cpu_sram_req &&
                (cpu_sram_addr[`SRAM_BLOCK_BIT] == dma_sram_addr[`SRAM_BLOCK_BIT])); // RULE1
        end
    end

    // Flash read path; a stalled fetch gets no answer and must be asked again
    always @(posedge clock) begin
        if (!rstn) begin
            flash_rdata <= 64'h0000_0000_0000_0000;
            ecc_hit_single <= 1'b0;
            ecc_hit_double <= 1'b0;
            flash_rvalid <= 1'b0;
            flash_denied <= 1'b0;
            flash_stall <= 1'b0;
            ecc_error_event <= 1'b0;
        end else begin
            flash_rvalid <= 1'b0;
            flash_denied <= 1'b0;
            ecc_error_event <= 1'b0;
            ecc_hit_single <= 1'b0;
            ecc_hit_double <= 1'b0;
            flash_stall <= flash_req && flash_fetch && flash_program_busy; // RULE6
            if (flash_req && !(flash_fetch && flash_program_busy)) begin
                if ((flash_fetch && flash_check_area) || // RULE5
                    !allow_access(prot_level[flash_row], flash_external, 1'b0)) begin // RULE9
                    flash_denied <= 1'b1;
                end else begin
                    flash_rvalid <= 1'b1;
                    flash_rdata <= corrected; // RULE4
                    ecc_error_event <= ecc_armed && (single_err || double_err); // RULE2
                    ecc_hit_single <= ecc_armed && single_err; // RULE2
                    ecc_hit_double <= ecc_armed && double_err; // RULE2
                end
            end
        end
    end

    // Row protection: writes only while a full erase is pending
    // External programming never changes a level
    always @(posedge clock) begin
        if (!rstn) begin
            prot_write_ok <= 1'b0;
            prot_erase_req <= 1'b0;
            for (i = 0; i < PROT_ROWS; i = i + 1)
                prot_level[i] <= `PROT_NONE;
        end else begin
            prot_write_ok <= 1'b0;
            if (reg_write && reg_addr == `REG_PROTECT_ERASE && reg_wdata[0]) begin
                prot_erase_req <= 1'b1;
                for (i = 0; i < PROT_ROWS; i = i + 1)
                    prot_level[i] <= `PROT_NONE; // RULE8
            end else if (prot_write && prot_erase_req && !prot_external) begin
                prot_level[prot_row] <= reg_wdata[1:0]; // RULE8
                prot_write_ok <= 1'b1;
                // The last row's write closes the window until the next full erase
                if (prot_row == {ROW_W{1'b1}})
                    prot_erase_req <= 1'b0; // RULE8
            end else if (prot_write && prot_row == {ROW_W{1'b1}}) begin
                prot_erase_req <= 1'b0;
            end
        end
    end

    // EEPROM: direct byte reads, row writes only
    always @(posedge clock) begin
        if (!rstn) begin
            ee_rdata <= 8'h00;
            ee_rvalid <= 1'b0;
            ee_fault <= 1'b0;
        end else begin
            ee_rvalid <= ee_read && !ee_fetch; // RULE10
            // A fetch attempt answers with a fault and never with data
            ee_fault <= ee_fetch; // RULE12
            if (ee_read && !ee_fetch)
                ee_rdata <= ee_mem[ee_addr]; // RULE12
        end
    end

    // Whole rows only; there is no single-byte write path
    always @(posedge clock) begin
        if (ee_row_write) begin
            for (e = 0; e < `EE_ROW_BYTES; e = e + 1)
                ee_mem[{ee_row, e[3:0]}] <= ee_row_data[e*8 +: 8]; // RULE11
        end
    end

    // Status and error flags, set wins over clear
    always @(posedge clock) begin
        if (!rstn) begin
            err_single <= 1'b0;
            err_double <= 1'b0;
        end else begin
            if (ecc_hit_single)
                err_single <= 1'b1;
            else if (reg_write && reg_addr == `REG_ERR_CLEAR && reg_wdata[0])
                err_single <= 1'b0;
            if (ecc_hit_double)
                err_double <= 1'b1;
            else if (reg_write && reg_addr == `REG_ERR_CLEAR && reg_wdata[1])
                err_double <= 1'b0;
        end
    end

    // Read data stand for the one cycle after the strobe and are zero otherwise
    always @(posedge clock) begin
        if (!rstn) begin
            reg_rdata <= 8'h00;
        end else if (reg_read) begin
            case (reg_addr)
                `REG_LATCH0: reg_rdata <= cfg[0];
                `REG_LATCH1: reg_rdata <= cfg[1];
                `REG_LATCH2: reg_rdata <= cfg[2];
                `REG_LATCH3: reg_rdata <= cfg[3];
                `REG_STATUS: reg_rdata <= {4'h0, prot_erase_req, cfg_internal_resetn, err_double, err_single};
                default: reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

endmodule // nvm_access

// *** bench/nvm_access_props.sv ***
// Port checker for the memory access block
`timescale 1ns/1ps
module nvm_access_props #(
    parameter PROT_ROWS = 16,
    parameter ROW_W = 4
) (
    input wire clock,
    input wire rstn,
    input wire cpu_sram_req,
    input wire [15:0] cpu_sram_addr,
    input wire dma_sram_req,
    input wire [15:0] dma_sram_addr,
    input wire cpu_sram_grant,
    input wire dma_sram_grant,
    input wire flash_req,
    input wire flash_fetch,
    input wire flash_check_area,
    input wire flash_program_busy,
    input wire flash_rvalid,
    input wire flash_denied,
    input wire flash_stall,
    input wire ecc_error_event,
    input wire ee_read,
    input wire ee_fetch,
    input wire ee_rvalid,
    input wire ee_fault,
    input wire cfg_internal_resetn,
    input wire debug_access_enable,
    input wire [1:0] debug_port_select,
    input wire check_region_enable
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    property p_split;
        cpu_sram_req && dma_sram_req && cpu_sram_addr[15] != dma_sram_addr[15] |=> cpu_sram_grant && dma_sram_grant;
    endproperty
    a_split: assert property (p_split) else $error("split grant");
    property p_same;
        cpu_sram_req && dma_sram_req && cpu_sram_addr[15] == dma_sram_addr[15] |=> cpu_sram_grant && !dma_sram_grant;
    endproperty
    a_same: assert property (p_same) else $error("same block grant");
    property p_stall;
        flash_req && flash_fetch && flash_program_busy |=> flash_stall && !flash_rvalid;
    endproperty
    a_stall: assert property (p_stall) else $error("no stall");
    property p_chk_fetch;
        flash_req && flash_fetch && flash_check_area && !flash_program_busy |=> flash_denied && !flash_rvalid;
    endproperty
    a_chk_fetch: assert property (p_chk_fetch) else $error("check fetch");
    property p_ee_fetch;
        ee_read && ee_fetch |=> ee_fault && !ee_rvalid;
    endproperty
    a_ee_fetch: assert property (p_ee_fetch) else $error("ee fetch");
    property p_ee_read;
        ee_read && !ee_fetch |=> ee_rvalid && !ee_fault;
    endproperty
    a_ee_read: assert property (p_ee_read) else $error("ee read");
    property p_release;
        $rose(rstn) |-> debug_access_enable && debug_port_select == 2'b01 && !cfg_internal_resetn;
    endproperty
    a_release: assert property (p_release) else $error("reset values");
    property p_freeze;
        cfg_internal_resetn && $past(cfg_internal_resetn) |-> $stable(debug_access_enable) && $stable(check_region_enable);
    endproperty
    a_freeze: assert property (p_freeze) else $error("config moved");
    property p_ecc;
        ecc_error_event |-> flash_rvalid && check_region_enable;
    endproperty
    a_ecc: assert property (p_ecc) else $error("ecc event");
    c_stall: cover property (flash_stall);
    c_ecc: cover property (ecc_error_event);
    c_split: cover property (cpu_sram_grant && dma_sram_grant);
endmodule // nvm_access_props
bind nvm_access nvm_access_props #(.PROT_ROWS(PROT_ROWS), .ROW_W(ROW_W)) props (.*);

// *** bench/flash_array_model.sv ***
// Flash array model giving stored words with injected faults
`timescale 1ns/1ps
module flash_array_model (
    input wire flash_req,
    input wire [71:0] fault_mask,
    output wire [71:0] flash_word
);
    // Zero data with its zero check byte; off-request the lines show the inverse
    localparam [71:0] STORED = 72'h00_0000_0000_0000_0000;
    assign flash_word = flash_req ? STORED ^ fault_mask : ~(STORED ^ fault_mask);
endmodule // flash_array_model

// *** bench/testbench.sv ***
// Self-checking bench for the memory access block
`timescale 1ns/1ps
`include "nvm_access_defines.vh"
module testbench;
    reg clock = 1'b0, rstn = 1'b0, reg_write = 1'b0, reg_read = 1'b0, cpu_sram_req = 1'b0, dma_sram_req = 1'b0;
    reg flash_req = 1'b0, flash_fetch = 1'b0, flash_check_area = 1'b0, flash_external = 1'b0;
    reg flash_program_busy = 1'b0, prot_write = 1'b0, prot_external = 1'b0, ee_read = 1'b0, ee_fetch = 1'b0;
    reg ee_row_write = 1'b0, cfg_load = 1'b0, dn;
    reg [3:0] reg_addr = 4'h0, flash_row = 4'h0, prot_row = 4'h0;
    reg [7:0] reg_wdata = 8'h00;
    reg [15:0] cpu_sram_addr = 16'h0000, dma_sram_addr = 16'h0000;
    reg [10:0] ee_addr = 11'h000;
    reg [6:0] ee_row = 7'h00;
    reg [127:0] ee_row_data = 128'h0;
    reg [31:0] cfg_bytes = 32'h0000_0000, cfg;
    reg [71:0] fault = 72'h0;
    wire [7:0] reg_rdata, ee_rdata;
    wire cpu_sram_grant, dma_sram_grant, flash_rvalid, flash_denied, flash_stall, ecc_error_event, prot_write_ok;
    wire ee_rvalid, ee_fault, cfg_internal_resetn, reset_pin_function_select, debug_access_enable;
    wire boot_clock_speed_select, check_region_enable;
    wire [1:0] debug_port_select;
    wire [3:0] digital_clock_phase_delay;
    wire [15:0] port_reset_drive_mode;
    wire [63:0] flash_rdata;
    wire [71:0] flash_word;
    integer fails = 0, n_checks = 0, cycles = 0, i, j;
    localparam [95:0] CFGS = 96'h1980_B1D8_AD40_4E27_7600_1BE4;
    nvm_access dut (.*);
    flash_array_model fam (.flash_req(flash_req), .fault_mask(fault), .flash_word(flash_word));
    always #2 clock = ~clock;
    task chk(input string name, input [127:0] seen, input [127:0] exp);
        begin
            n_checks = n_checks + 1;
            if (seen !== exp) begin
                fails = fails + 1;
                $display("Error %0s expected %0h seen %0h", name, exp, seen);
            end
        end
    endtask
    task summarize;
        begin
            $display("Checks %0d mismatches %0d", n_checks, fails);
            if (fails == 0 && n_checks > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask
    always @(posedge clock) begin
        cycles = cycles + 1;
        if (cycles == 3000) begin
            fails = fails + 1;
            summarize;
        end
    end
    task do_reset(input [31:0] c);
        begin
            @(posedge clock);
            rstn <= 1'b0;
            cfg_bytes <= c;
            repeat (6) @(posedge clock);
            rstn <= 1'b1;
            @(posedge clock);
            cfg_load <= 1'b1;
            @(posedge clock);
            cfg_load <= 1'b0;
            repeat (3) @(posedge clock);
            #1;
        end
    endtask
    // Write when w, else read and compare the data of the following cycle
    task bus(input w, input [3:0] a, input [7:0] d);
        begin
            @(posedge clock);
            reg_addr <= a;
            reg_wdata <= d;
            reg_write <= w;
            reg_read <= !w;
            @(posedge clock);
            reg_write <= 1'b0;
            reg_read <= 1'b0;
            #1;
            if (!w) chk("reg_rdata", reg_rdata, d);
        end
    endtask
    // ctl is fetch, check area, external, busy; exp is rvalid, denied, stall, event
    task fl(input [3:0] ctl, input [3:0] r, input [71:0] m, input [3:0] exp, input [63:0] x);
        begin
            @(posedge clock);
            {flash_fetch, flash_check_area, flash_external, flash_program_busy} <= ctl;
            flash_req <= 1'b1;
            flash_row <= r;
            fault <= m;
            @(posedge clock);
            flash_req <= 1'b0;
            flash_program_busy <= 1'b0;
            #1;
            chk("flash", {flash_rvalid, flash_denied, flash_stall, ecc_error_event}, exp);
            if (exp[3]) chk("flash_rdata", flash_rdata, x);
        end
    endtask
    // Drives one of three request kinds and compares the one-cycle answer
    task req(input [1:0] kind, input [15:0] a, input [15:0] b, input [7:0] exp);
        integer k;
        begin
            @(posedge clock);
            for (k = 0; k < 16; k = k + 1) ee_row_data[8*k +: 8] <= 8'h30 + k[7:0];
            cpu_sram_req <= kind == 2'd0;
            dma_sram_req <= kind == 2'd0;
            cpu_sram_addr <= a;
            dma_sram_addr <= b;
            prot_write <= kind == 2'd1;
            prot_row <= a[3:0];
            reg_wdata <= b[7:0];
            ee_read <= kind == 2'd2;
            ee_fetch <= kind == 2'd2 && b[0];
            ee_addr <= a[10:0];
            @(posedge clock);
            {cpu_sram_req, dma_sram_req, prot_write, ee_read, ee_fetch} <= 5'h00;
            #1;
            if (kind == 2'd0) chk("grant", {cpu_sram_grant, dma_sram_grant}, exp[1:0]);
            if (kind == 2'd1) chk("prot_write_ok", prot_write_ok, exp[0]);
            if (kind == 2'd2) chk("ee", {ee_rvalid, ee_fault}, {!b[0], b[0]});
            if (kind == 2'd2 && !b[0]) chk("ee_rdata", ee_rdata, exp);
        end
    endtask
    initial begin
        for (i = 0; i < 3; i = i + 1) begin
            cfg = CFGS[32*i +: 32];
            do_reset(cfg);
            chk("drive", {port_reset_drive_mode, reset_pin_function_select}, {cfg[15:0], cfg[23]});
            chk("debug", {debug_access_enable, debug_port_select}, {cfg[22], cfg[26:25]});
            chk("speed", boot_clock_speed_select, cfg[24]);
            chk("cfg", {check_region_enable, digital_clock_phase_delay, cfg_internal_resetn}, {cfg[27], cfg[31:28], 1'b1});
            for (j = 0; j < 4; j = j + 1) bus(1'b0, j[3:0], cfg[8*j +: 8]);
            fl(4'h0, 4'h0, 72'h1, {2'b10, 1'b0, cfg[27]}, {63'h0, !cfg[27]});
        end
        fl(4'h0, 4'h0, 72'h03_0000_0000_0000_0000, 4'h9, 64'h0);
        bus(1'b0, `REG_STATUS, 8'h07);
        bus(1'b1, `REG_ERR_CLEAR, 8'h03);
        bus(1'b0, `REG_STATUS, 8'h04);
        bus(1'b0, 4'hF, 8'h00);
        bus(1'b1, `REG_LATCH0, 8'h5A);
        bus(1'b0, `REG_LATCH0, 8'h5A);
        chk("drive", port_reset_drive_mode, cfg[15:0]);
        req(2'd0, 16'h0010, 16'h8010, 8'h03);
        req(2'd0, 16'h8000, 16'h8004, 8'h02);
        bus(1'b1, `REG_PROTECT_ERASE, 8'h01);
        for (i = 1; i < 4; i = i + 1) req(2'd1, i, i, 8'h01);
        req(2'd1, 16'h000F, 16'h0000, 8'h01);
        req(2'd1, 16'h0001, 16'h0000, 8'h00);
        for (i = 0; i < 8; i = i + 1) begin
            dn = i[0] && i[2:1] != 2'b00;
            fl({2'b00, i[0], 1'b0}, {2'b00, i[2:1]}, 72'h0, {!dn, dn, 2'b00}, 64'h0);
        end
        fl(4'h9, 4'h0, 72'h0, 4'h2, 64'h0);
        fl(4'hC, 4'h0, 72'h0, 4'h4, 64'h0);
        fl(4'h8, 4'h0, 72'h0, 4'h8, 64'h0);
        @(posedge clock);
        ee_row <= 7'h05;
        ee_row_write <= 1'b1;
        @(posedge clock);
        ee_row_write <= 1'b0;
        req(2'd2, 16'h0050, 16'h0000, 8'h30);
        req(2'd2, 16'h005F, 16'h0000, 8'h3F);
        req(2'd2, 16'h005F, 16'h0001, 8'h00);
        summarize;
    end
endmodule // testbench
